// ### gcr_color_regs.sv
// colour register set and transparency decision of the drawing engine
//
// Overview of operation
// - background colour held in bits 23:0
// - foreground colour held in bits 23:0
// - transparency key colour held in bits 23:0
// - compare mask applied during key comparison
// - only depth-sized low bits are used
// - 8:8:8 splits red, green, blue bytes
// - only colour mode uses key compare
// - select compares source or destination pixel
// - polarity picks drawn side of match
// - source select 10/11 picks bg/fg
`default_nettype none

module gcr_color_regs #(
	parameter int ADDR_W = 32 // register bus address width
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              reset_n,
	// register bus
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_write,
	input  wire logic              reg_read,
	output logic      [31:0]       reg_rdata,
	// pixel stream from the drawing datapath
	input  wire logic              pix_valid,
	input  wire logic [23:0]       src_pixel,
	input  wire logic [23:0]       dst_pixel,
	input  wire logic [23:0]       mem_data,
	// decision and source data to the datapath
	output logic                   out_valid,
	output logic                   pixel_draw,
	output logic      [23:0]       src_data,
	output logic      [7:0]        src_red,
	output logic      [7:0]        src_green,
	output logic      [7:0]        src_blue,
	// expansion colours for mono data
	output logic      [23:0]       bg_expand,
	output logic      [23:0]       fg_expand
);
	import gcr_pkg::*;

	// ************************************************************
	// elaboration checks
	// ************************************************************
	// the printed addresses need a full 32-bit bus
	if (ADDR_W != 32) begin : g_bad_addr
		$error("gcr_color_regs: ADDR_W must be 32");
	end

	// ************************************************************
	// reset release
	// ************************************************************
	logic rst_meta_n; // first stage, read only by the second
	logic rst_n;      // released reset for the block

	// two flops so release is clean against clk
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_n <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n      <= rst_meta_n;
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	logic [23:0] background_color;          // background colour value
	logic [23:0] foreground_color;          // foreground colour value
	logic [23:0] transparency_key_color;    // key for colour transparency
	logic [23:0] transparency_compare_mask; // mask for key compare
	logic [1:0]  transparency_mode_field;   // off, mono or colour
	logic        compare_select;            // 0 source, 1 destination
	logic        key_match_polarity;        // 0 match hidden, 1 match drawn
	logic [1:0]  source_data_select;        // source of drawing data
	logic [1:0]  color_depth;               // bits per pixel code

	// address decode shared by write and read
	logic hit_bg;   // background address
	logic hit_fg;   // foreground address
	logic hit_key;  // key address
	logic hit_mask; // mask address
	logic hit_ctrl; // control address

	assign hit_bg   = reg_addr == GCR_BG_ADDR;
	assign hit_fg   = reg_addr == GCR_FG_ADDR;
	assign hit_key  = reg_addr == GCR_KEY_ADDR;
	assign hit_mask = reg_addr == GCR_MASK_ADDR;
	assign hit_ctrl = reg_addr == GCR_CTRL_ADDR;

	// background colour, reserved upper byte dropped
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			background_color <= GCR_COLOR_RST;
		end else if (reg_write && hit_bg) begin
			background_color <= reg_wdata[23:0];
		end
	end

	// foreground colour
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			foreground_color <= GCR_COLOR_RST;
		end else if (reg_write && hit_fg) begin
			foreground_color <= reg_wdata[23:0];
		end
	end

	// transparency key colour
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			transparency_key_color <= GCR_COLOR_RST;
		end else if (reg_write && hit_key) begin
			transparency_key_color <= reg_wdata[23:0];
		end
	end

	// transparency compare mask
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			transparency_compare_mask <= GCR_COLOR_RST;
		end else if (reg_write && hit_mask) begin
			transparency_compare_mask <= reg_wdata[23:0];
		end
	end

	// control fields steering the decision path
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			transparency_mode_field <= GCR_CTRL_RST[GCR_TMODE_LSB +: 2];
			compare_select          <= GCR_CTRL_RST[GCR_CSEL_BIT];
			key_match_polarity      <= GCR_CTRL_RST[GCR_POL_BIT];
			source_data_select      <= GCR_CTRL_RST[GCR_SOURCE_DATA_SELECT_LSB +: 2];
			color_depth             <= GCR_CTRL_RST[GCR_BPP_LSB +: 2];
		end else if (reg_write && hit_ctrl) begin
			transparency_mode_field <= reg_wdata[GCR_TMODE_LSB +: 2];
			compare_select          <= reg_wdata[GCR_CSEL_BIT];
			key_match_polarity      <= reg_wdata[GCR_POL_BIT];
			source_data_select      <= reg_wdata[GCR_SOURCE_DATA_SELECT_LSB +: 2];
			color_depth             <= reg_wdata[GCR_BPP_LSB +: 2];
		end
	end

	// ************************************************************
	// register read
	// ************************************************************
	logic [31:0] next_rdata; // word for the cycle after the read

	// reserved bits and unmapped addresses read zero
	always_comb begin
		next_rdata = 32'h00000000;
		if (hit_bg) begin
			next_rdata[23:0] = background_color;
		end else if (hit_fg) begin
			next_rdata[23:0] = foreground_color;
		end else if (hit_key) begin
			next_rdata[23:0] = transparency_key_color;
		end else if (hit_mask) begin
			next_rdata[23:0] = transparency_compare_mask;
		end else if (hit_ctrl) begin
			next_rdata[GCR_TMODE_LSB +: 2] = transparency_mode_field;
			next_rdata[GCR_CSEL_BIT]       = compare_select;
			next_rdata[GCR_POL_BIT]        = key_match_polarity;
			next_rdata[GCR_SOURCE_DATA_SELECT_LSB +: 2]  = source_data_select;
			next_rdata[GCR_BPP_LSB +: 2]   = color_depth;
		end
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_read) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	// ************************************************************
	// transparency decision
	// ************************************************************
	logic [23:0] depth;         // meaningful low bits for this depth
	logic [23:0] cmp_pixel;     // pixel that controls transparency
	logic        key_match;     // masked match against the key
	logic [23:0] next_src_data; // selected source data
	logic        next_draw;     // draw decision for this pixel

	assign depth = gcr_depth_mask(color_depth);

	assign cmp_pixel = compare_select ? dst_pixel : src_pixel;

	gcr_key_compare u_key_compare (
		.pixel (cmp_pixel),
		.key   (transparency_key_color),
		.mask  (transparency_compare_mask),
		.depth (depth),
		.match (key_match)
	);

	gcr_source_mux u_source_mux (
		.source_data_select (source_data_select),
		.mem_data           (mem_data),
		.background_color   (background_color),
		.foreground_color   (foreground_color),
		.depth              (depth),
		.src_data           (next_src_data)
	);

	// mono transparency is decided elsewhere, so it draws here
	always_comb begin
		if (transparency_mode_field == GCR_TMODE_COLOR) begin
			next_draw = key_match == key_match_polarity;
		end else begin
			next_draw = 1'b1;
		end
	end

	// one-cycle stage from pixel in to decision out
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid  <= 1'b0;
			pixel_draw <= 1'b0;
			src_data   <= 24'h000000;
		end else begin
			out_valid <= pix_valid;
			if (pix_valid) begin
				pixel_draw <= next_draw;
				src_data   <= next_src_data;
			end
		end
	end

	assign src_red   = src_data[GCR_RED_LSB +: 8];
	assign src_green = src_data[GCR_GREEN_LSB +: 8];
	assign src_blue  = src_data[GCR_BLUE_LSB +: 8];

	// expansion colours trimmed to the current depth
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bg_expand <= 24'h000000;
			fg_expand <= 24'h000000;
		end else begin
			bg_expand <= background_color & depth;
			fg_expand <= foreground_color & depth;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_bg_readback: assert property (
		reg_read && hit_bg |=> reg_rdata == {8'h00, $past(background_color)})
		else $error("background read mismatch");
	a_fg_write: assert property (
		reg_write && hit_fg ##1 reg_read && hit_fg
		|=> reg_rdata[23:0] == $past(reg_wdata[23:0], 2))
		else $error("foreground write not read back");
	a_rsvd_zero: assert property (
		reg_rdata[31:24] == 8'h00) else $error("reserved bits not zero");
	a_mask_ignore: assert property (
		pix_valid && transparency_mode_field == GCR_TMODE_COLOR
		&& (transparency_compare_mask & depth) == 24'h000000
		|=> pixel_draw == $past(key_match_polarity))
		else $error("empty mask must always match");
	a_depth_trim: assert property (
		(src_data & ~depth) == 24'h000000 || $changed(color_depth)
		|| $past(!pix_valid)) else $error("source data exceeds depth");
	a_key_match: assert property (
		key_match == (((cmp_pixel ^ transparency_key_color)
		& transparency_compare_mask & depth) == 24'h000000))
		else $error("key compare wrong");
	a_mode_off: assert property (
		pix_valid && transparency_mode_field != GCR_TMODE_COLOR |=> pixel_draw)
		else $error("pixel hidden outside colour mode");
	a_dst_select: assert property (
		pix_valid && transparency_mode_field == GCR_TMODE_COLOR && compare_select
		&& ((dst_pixel ^ transparency_key_color) & transparency_compare_mask
		& depth) != 24'h000000
		|=> pixel_draw == !$past(key_match_polarity)) else $error("wrong compare pixel");
	a_hide_match: assert property (
		pix_valid && transparency_mode_field == GCR_TMODE_COLOR && key_match
		&& !key_match_polarity |=> out_valid && !pixel_draw)
		else $error("matching pixel drawn");
	a_src_fg: assert property (
		pix_valid && source_data_select == GCR_SRC_FG
		|=> src_data == $past(foreground_color & depth)) else $error("fg source wrong");
	a_unmapped: assert property (
		reg_read && !(hit_bg || hit_fg || hit_key || hit_mask || hit_ctrl)
		|=> reg_rdata == 32'h00000000) else $error("unmapped read not zero");

	c_hidden: cover property (pix_valid && transparency_mode_field == GCR_TMODE_COLOR
		##1 !pixel_draw);
	c_dst_match: cover property (pix_valid && compare_select && key_match);
	c_bg_source: cover property (pix_valid && source_data_select == GCR_SRC_BG);
	c_write_read: cover property (reg_write && hit_key ##1 reg_read && hit_key);

endmodule

`default_nettype wire

// ### gcr_key_compare.sv
// masked comparison of one pixel against the transparency key
`default_nettype none

module gcr_key_compare (
	// operands
	input  wire logic [23:0] pixel,
	input  wire logic [23:0] key,
	input  wire logic [23:0] mask,
	input  wire logic [23:0] depth,
	// result
	output logic             match
);
	import gcr_pkg::*;

	// ************************************************************
	// comparison
	// ************************************************************
	// only bits set in both mask and depth take part
	logic [23:0] care; // positions that are compared

	assign care  = mask & depth;
	assign match = ((pixel ^ key) & care) == 24'h000000;

endmodule

`default_nettype wire

// ### gcr_pkg.sv
// constants and helpers shared by the colour register block
`default_nettype none

package gcr_pkg;

	// ************************************************************
	// register map (byte addresses)
	// ************************************************************
	localparam logic [31:0] GCR_BG_ADDR   = 32'hB000B024; // background colour
	localparam logic [31:0] GCR_FG_ADDR   = 32'hB000B028; // foreground colour
	localparam logic [31:0] GCR_KEY_ADDR  = 32'hB000B02C; // transparency key colour
	localparam logic [31:0] GCR_MASK_ADDR = 32'hB000B030; // transparency compare mask
	localparam logic [31:0] GCR_CTRL_ADDR = 32'hB000B0F0; // drawing control bits

	// ************************************************************
	// reset values and field positions
	// ************************************************************
	localparam logic [23:0] GCR_COLOR_RST = 24'h000000; // every colour register
	localparam logic [31:0] GCR_CTRL_RST  = 32'h00000000; // control register
	localparam int          GCR_COLOR_W   = 24;  // stored colour width
	localparam int          GCR_TMODE_LSB = 14;  // transparency mode field [15:14]
	localparam int          GCR_CSEL_BIT  = 12;  // compare select bit
	localparam int          GCR_POL_BIT   = 11;  // key match polarity bit
	localparam int          GCR_SOURCE_DATA_SELECT_LSB  = 5;   // source data select [6:5]
	localparam int          GCR_BPP_LSB   = 0;   // colour depth [1:0]
	localparam int          GCR_RED_LSB   = 16;  // red channel in 8:8:8
	localparam int          GCR_GREEN_LSB = 8;   // green channel in 8:8:8
	localparam int          GCR_BLUE_LSB  = 0;   // blue channel in 8:8:8

	// ************************************************************
	// field encodings
	// ************************************************************
	localparam logic [1:0] GCR_TMODE_OFF   = 2'h0; // no transparency
	localparam logic [1:0] GCR_TMODE_MONO  = 2'h1; // mono transparency
	localparam logic [1:0] GCR_TMODE_COLOR = 2'h2; // colour key transparency
	localparam logic [1:0] GCR_SRC_DISP    = 2'h0; // display memory
	localparam logic [1:0] GCR_SRC_SYS     = 2'h1; // system memory
	localparam logic [1:0] GCR_SRC_BG      = 2'h2; // background colour register
	localparam logic [1:0] GCR_SRC_FG      = 2'h3; // foreground colour register
	localparam logic [1:0] GCR_BPP_8       = 2'h0; // 8 bits per pixel
	localparam logic [1:0] GCR_BPP_16      = 2'h1; // 16 bits per pixel
	localparam logic [1:0] GCR_BPP_24      = 2'h2; // 24 bits per pixel

	// low-order bits that the current depth makes meaningful
	function automatic logic [23:0] gcr_depth_mask(input logic [1:0] bpp);
		case (bpp)
			GCR_BPP_8:  gcr_depth_mask = 24'h0000FF;
			GCR_BPP_16: gcr_depth_mask = 24'h00FFFF;
			default:    gcr_depth_mask = 24'hFFFFFF;
		endcase
	endfunction

endpackage

`default_nettype wire

// ### gcr_source_mux.sv
// selection of source data between memory and colour registers
`default_nettype none

module gcr_source_mux (
	// selection
	input  wire logic [1:0]  source_data_select,
	// candidates
	input  wire logic [23:0] mem_data,
	input  wire logic [23:0] background_color,
	input  wire logic [23:0] foreground_color,
	input  wire logic [23:0] depth,
	// result
	output logic      [23:0] src_data
);
	import gcr_pkg::*;

	// ************************************************************
	// selection
	// ************************************************************
	// both memory sources arrive on the same fetched word
	always_comb begin
		case (source_data_select)
			GCR_SRC_BG: src_data = background_color & depth;
			GCR_SRC_FG: src_data = foreground_color & depth;
			default:    src_data = mem_data & depth;
		endcase
	end

endmodule

`default_nettype wire

// ### test_gcr_color_regs.sv
// self-checking testbench of the colour register block
`default_nettype none

module test_gcr_color_regs;
	timeunit 1ns;
	timeprecision 100ps;
	import gcr_pkg::*;

	// ************************************************************
	// signals and constants
	// ************************************************************
	localparam logic [23:0] KEYV = 24'h123456; // key colour used by the pixel tests
	localparam logic [23:0] MSKV = 24'hFFF0F0; // compare mask, some bits cleared
	localparam logic [23:0] BGV  = 24'h89ABCD; // background colour
	localparam logic [23:0] FGV  = 24'h13579B; // foreground colour
	localparam logic [23:0] MEMV = 24'hA5C3E1; // fetched source data
	logic        clk;        // 50 MHz clock
	logic        reset_n;    // active low reset
	logic [31:0] reg_addr;   // register address
	logic [31:0] reg_wdata;  // register write data
	logic        reg_write;  // write strobe
	logic        reg_read;   // read strobe
	logic [31:0] reg_rdata;  // read data
	logic        pix_valid;  // pixel strobe
	logic [23:0] src_pixel;  // source pixel
	logic [23:0] dst_pixel;  // destination pixel
	logic [23:0] mem_data;   // memory source data
	logic        out_valid;  // decision strobe
	logic        pixel_draw; // draw decision
	logic [23:0] src_data;   // selected source data
	logic [7:0]  src_red;    // red slice
	logic [7:0]  src_green;  // green slice
	logic [7:0]  src_blue;   // blue slice
	logic [23:0] bg_expand;  // background expansion colour
	logic [23:0] fg_expand;  // foreground expansion colour
	int          failures;   // mismatches seen
	int          cmp_count;  // comparisons made
	logic [31:0] rd;         // last read word
	logic [31:0] regs [4] = '{GCR_BG_ADDR, GCR_FG_ADDR, GCR_KEY_ADDR, GCR_MASK_ADDR};
	logic [23:0] pixset [4] = '{KEYV ^ 24'h000F0F, KEYV ^ 24'h010000,
		KEYV ^ 24'h001000, KEYV ^ 24'h000010};

	// design under test, every input driven
	gcr_color_regs #(.ADDR_W(32)) u_dut (
		.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.pix_valid(pix_valid), .src_pixel(src_pixel), .dst_pixel(dst_pixel),
		.mem_data(mem_data), .out_valid(out_valid), .pixel_draw(pixel_draw),
		.src_data(src_data), .src_red(src_red), .src_green(src_green),
		.src_blue(src_blue), .bg_expand(bg_expand), .fg_expand(fg_expand)
	);

	// clock toggles every half period
	always #10 clk = ~clk;

	// ************************************************************
	// helpers
	// ************************************************************
	// meaningful low bits for a colour depth code
	function automatic logic [23:0] dmask(input logic [1:0] b);
		return (b == 2'h0) ? 24'h0000FF : (b == 2'h1) ? 24'h00FFFF : 24'hFFFFFF;
	endfunction

	// control word: mode, compare select, polarity, source select, depth
	function automatic logic [31:0] ctrl(input logic [1:0] mo, input logic c,
		input logic p, input logic [1:0] s, input logic [1:0] b);
		return {16'h0000, mo, 1'b0, c, p, 4'h0, s, 3'h0, b};
	endfunction

	// compare and report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// one write cycle
	task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_write <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask

	// one read cycle, data taken in the following cycle
	task automatic reg_rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// one pixel, then inputs scrambled so only the sampled values count
	task automatic pix(input logic [23:0] s, input logic [23:0] d);
		@(posedge clk);
		pix_valid <= 1'b1;
		src_pixel <= s;
		dst_pixel <= d;
		mem_data  <= MEMV;
		@(posedge clk);
		pix_valid <= 1'b0;
		src_pixel <= ~s;
		dst_pixel <= ~d;
		mem_data  <= ~MEMV;
		#1;
	endtask

	// reset held for five cycles, requests wait for the synchroniser
	task automatic do_reset;
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
	endtask

	// verdict and end of run
	task automatic end_of_test;
		if (failures == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ************************************************************
	// watchdog
	// ************************************************************
	// the tests need about 1100 cycles
	initial begin
		repeat (6000) @(posedge clk);
		failures++;
		end_of_test();
	end

	// ************************************************************
	// test sequence
	// ************************************************************
	initial begin
		logic [23:0] es;  // expected source data
		logic        mt;  // expected key match
		logic        ed;  // expected draw
		logic [23:0] dm;  // depth mask
		clk = 1'b0;
		reset_n = 1'b0;
		reg_addr = 32'h00000000;
		reg_wdata = 32'h00000000;
		reg_write = 1'b0;
		reg_read = 1'b0;
		pix_valid = 1'b0;
		src_pixel = 24'h000000;
		dst_pixel = 24'h000000;
		mem_data = 24'h000000;
		failures = 0;
		cmp_count = 0;
		do_reset();
		// reset values, then all ones to see the reserved byte read back zero
		for (int i = 0; i < 4; i++) begin
			reg_rd(regs[i], rd);
			chk(rd, 32'h00000000, "reset value");
			reg_wr(regs[i], 32'hFFFFFFFF);
			reg_rd(regs[i], rd);
			chk(rd, 32'h00FFFFFF, "colour width");
		end
		// unmapped address neither stores nor aliases
		reg_wr(32'hB000B034, 32'h00000000);
		reg_wr(32'hB100B024, 32'h00000000);
		reg_rd(32'hB000B034, rd);
		chk(rd, 32'h00000000, "unmapped read");
		reg_rd(GCR_BG_ADDR, rd);
		chk(rd, 32'h00FFFFFF, "unmapped write alias");
		// write then read with no gap between strobes
		@(posedge clk);
		reg_write <= 1'b1;
		reg_addr  <= GCR_FG_ADDR;
		reg_wdata <= 32'hAB123456;
		@(posedge clk);
		reg_write <= 1'b0;
		reg_read  <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 chk(reg_rdata, 32'h00123456, "back to back read");
		@(posedge clk);
		#1 chk(reg_rdata, 32'h00000000, "read data one cycle");
		// second reset clears the registers again
		do_reset();
		reg_rd(GCR_FG_ADDR, rd);
		chk(rd, 32'h00000000, "second reset");
		reg_wr(GCR_BG_ADDR, {8'hFF, BGV});
		reg_wr(GCR_FG_ADDR, {8'h00, FGV});
		reg_wr(GCR_KEY_ADDR, {8'h00, KEYV});
		reg_wr(GCR_MASK_ADDR, {8'h00, MSKV});
		pix(24'h000000, 24'h000000);
		@(posedge clk);
		#1 chk({31'h0, out_valid}, 32'h00000000, "valid one cycle");
		// every depth, mode, polarity, compare select and source select
		for (int b = 0; b < 4; b++) begin
			dm = dmask(2'(b));
			for (int mo = 0; mo < 4; mo++) begin
				for (int p = 0; p < 2; p++) begin
					for (int c = 0; c < 2; c++) begin
						for (int i = 0; i < 4; i++) begin
							reg_wr(32'hB000B0F0, ctrl(2'(mo), 1'(c), 1'(p), 2'(i), 2'(b)));
							pix(pixset[i], pixset[3 - i]);
							mt = (((((c == 1) ? pixset[3 - i] : pixset[i]) ^ KEYV) & MSKV & dm)
								== 24'h000000);
							ed = (2'(mo) == GCR_TMODE_COLOR) ? (mt == 1'(p)) : 1'b1;
							es = (i == 2) ? BGV : (i == 3) ? FGV : MEMV;
							chk({31'h0, out_valid}, 32'h00000001, "out valid");
							chk({31'h0, pixel_draw}, {31'h0, ed}, "draw");
							chk({8'h00, src_data}, {8'h00, es & dm}, "source");
							chk({8'h00, src_red, src_green, src_blue}, {8'h00, es & dm}, "rgb");
							chk({8'h00, bg_expand}, {8'h00, BGV & dm}, "bg expand");
							chk({8'h00, fg_expand}, {8'h00, FGV & dm}, "fg expand");
						end
					end
				end
			end
		end
		// empty mask makes every pixel match the key
		reg_wr(GCR_MASK_ADDR, 32'h00000000);
		for (int p = 0; p < 2; p++) begin
			reg_wr(GCR_CTRL_ADDR, ctrl(GCR_TMODE_COLOR, 1'b0, 1'(p), GCR_SRC_DISP, GCR_BPP_24));
			pix(~KEYV, ~KEYV);
			chk({31'h0, pixel_draw}, {31'h0, 1'(p)}, "empty mask");
		end
		end_of_test();
	end

endmodule

`default_nettype wire
